/* tmr8_pkg.sv */
// shared constants for the 8-bit waveform timer
package tmr8_pkg;
  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL_A   = 8'h24;
  localparam logic [7:0] ADDR_CTRL_B   = 8'h25;
  localparam logic [7:0] ADDR_COUNT    = 8'h26;
  localparam logic [7:0] ADDR_CMP_A    = 8'h27;
  localparam logic [7:0] ADDR_CMP_B    = 8'h28;
  localparam logic [7:0] ADDR_FLAGS    = 8'h2c;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRLA_ACT_A_LSB = 6;
  localparam int CTRLA_ACT_B_LSB = 4;
  localparam int CTRLA_MODE_LSB  = 0;
  localparam int CTRLB_MODE_TOP  = 3;
  localparam int CTRLB_SRC_LSB   = 0;
  localparam int FLAG_OVF        = 0;
  localparam int FLAG_MATCH_A    = 1;
  localparam int FLAG_MATCH_B    = 2;
  localparam logic [7:0] CTRLA_WMASK = 8'hf3;
  localparam logic [7:0] CTRLB_WMASK = 8'h0f;
  // ----------------------------------------------------------------
  // reset values and fixed counter points
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_REG    = 8'h00;
  localparam logic [7:0] CNT_MAX    = 8'hff;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  // ----------------------------------------------------------------
  // mode and tick source encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_NORMAL  = 3'h0;
  localparam logic [2:0] MODE_PC_FF   = 3'h1;
  localparam logic [2:0] MODE_CLR_CMP = 3'h2;
  localparam logic [2:0] MODE_FAST_FF = 3'h3;
  localparam logic [2:0] MODE_PC_A    = 3'h5;
  localparam logic [2:0] MODE_FAST_A  = 3'h7;
  localparam logic [2:0] SRC_STOP     = 3'h0;
  localparam logic [2:0] SRC_DIV1     = 3'h1;
  localparam logic [2:0] SRC_DIV8     = 3'h2;
  localparam logic [2:0] SRC_DIV64    = 3'h3;
  localparam logic [2:0] SRC_DIV256   = 3'h4;
  localparam logic [2:0] SRC_DIV1024  = 3'h5;
  localparam logic [2:0] SRC_EXT_FALL = 3'h6;
  localparam logic [2:0] SRC_EXT_RISE = 3'h7;
  localparam int         PRESCALE_W   = 10;
endpackage

/* tmr8_tick_gen.sv */
// timer tick source: prescaler and external pin edge detect
`timescale 1ns/1ps
`default_nettype none
module tmr8_tick_gen #(
  parameter int PW = tmr8_pkg::PRESCALE_W
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // source select and external pin
  input  wire logic [2:0] tickSourceSelect,
  input  wire logic       extPin,
  // one-cycle enable pulse
  output logic            timerTickEnable
);
  logic [PW-1:0] preCnt_q, preCnt_d;
  logic [2:0]    extSync_q, extSync_d;

  // ----------------------------------------------------------------
  // next state: free-running prescaler, pin synchroniser
  // ----------------------------------------------------------------
  always_comb begin
    preCnt_d  = preCnt_q + PW'(1);
    extSync_d = {extSync_q[1:0], extPin};
  end

  // registers only
  always_ff @(posedge mclk) begin
    if (rst) begin
      preCnt_q  <= '0;
      extSync_q <= 3'h0;
    end else begin
      preCnt_q  <= preCnt_d;
      extSync_q <= extSync_d;
    end
  end

  // ----------------------------------------------------------------
  // tick select; edges read only stages 1 and 2 of the chain
  // ----------------------------------------------------------------
  always_comb begin
    case (tickSourceSelect)
      tmr8_pkg::SRC_STOP:     timerTickEnable = 1'b0;
      tmr8_pkg::SRC_DIV1:     timerTickEnable = 1'b1;
      tmr8_pkg::SRC_DIV8:     timerTickEnable = (preCnt_q[2:0] == 3'h7);
      tmr8_pkg::SRC_DIV64:    timerTickEnable = (preCnt_q[5:0] == 6'h3f);
      tmr8_pkg::SRC_DIV256:   timerTickEnable = (preCnt_q[7:0] == 8'hff);
      tmr8_pkg::SRC_DIV1024:  timerTickEnable = (preCnt_q[9:0] == 10'h3ff);
      tmr8_pkg::SRC_EXT_FALL: timerTickEnable = extSync_q[2] & ~extSync_q[1];
      default:                timerTickEnable = ~extSync_q[2] & extSync_q[1];
    endcase
  end
endmodule
`default_nettype wire

/* tmr8_wave_timer.sv */
// 8-bit timer with two compare channels and waveform outputs
// What this block does
// R1: counts on mclk, tick is an enable
// R2: B flag every mode; A flag every mode, also as TOP
// R3: A-as-TOP match sets A flag, clears counter in modes 2 and 7
// R4: nonzero action overrides the pin function, except A action 01 in modes 1 and 3
// R5: software sets pin direction to drive
// R6: non-PWM: off, toggle, clear, set on match
// R7: fast PWM A: clear/set match, opposite BOTTOM
// R8: A action 01 in PWM: toggle only if mode top bit
// R9: fast PWM B like A; 01 reserved
// R10: phase PWM A: up/down match opposite actions
// R11: phase PWM B: up/down match opposite actions
// R12: fast PWM A equals TOP: act at BOTTOM
// R13: phase PWM compare equals TOP: act at TOP
// R14: control A bits 3,2 read zero
// R15: mode field decodes six modes, two reserved
// R16: compare update timing; overflow flag timing
// R17: MAX is 0xff, BOTTOM is 0x00
// R18: tick source select stop, dividers, pin edges
// R19: normal mode overflow on MAX to 0x00
// R20: counter changes only on tick pulses and software writes
`timescale 1ns/1ps
`default_nettype none
module tmr8_wave_timer (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // avalon-mm slave
  input  wire logic [7:0] avsAddress,
  input  wire logic       avsRead,
  input  wire logic       avsWrite,
  input  wire logic [31:0] avsWriteData,
  input  wire logic [3:0] avsByteEnable,
  output logic [31:0]     avsReadData,
  output logic            avsWaitRequest,
  // pins
  input  wire logic       extTickPin,
  output logic            chanAWaveOut,
  output logic            chanBWaveOut,
  output logic            chanAPinOverride,
  output logic            chanBPinOverride
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {TMR8_IDLE = 2'b00, TMR8_ANS = 2'b01} tmr8_bus_e;
  tmr8_bus_e   busSt_q, busSt_d;
  logic [7:0]  ctrlA_q, ctrlA_d, ctrlB_q, ctrlB_d;
  logic [7:0]  count_q, count_d;
  logic [7:0]  cmpA_q, cmpA_d, cmpB_q, cmpB_d;      // active compare values
  logic [7:0]  bufA_q, bufA_d, bufB_q, bufB_d;      // software-written values
  logic [2:0]  flags_q, flags_d;
  logic        down_q, down_d;
  logic        waveA_q, waveA_d, waveB_q, waveB_d;
  logic        block_q, block_d;
  logic [31:0] rdata_q, rdata_d;
  logic        tick;
  logic [2:0]  mode;
  logic [7:0]  topVal;
  logic        isFast, isPc, isPwm, topFromA;
  logic        atTop, atBottom, wrap, matchA, matchB, countWr, wrAns;
  logic [7:0]  wbyte;

  // ----------------------------------------------------------------
  // tick generation
  // ----------------------------------------------------------------
  tmr8_tick_gen #(.PW(tmr8_pkg::PRESCALE_W)) uTick (
    .mclk            (mclk),
    .rst             (rst),
    .tickSourceSelect(ctrlB_q[2:0]),          // R18
    .extPin          (extTickPin),
    .timerTickEnable (tick)
  );

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  always_comb begin
    mode     = {ctrlB_q[tmr8_pkg::CTRLB_MODE_TOP], ctrlA_q[1:0]};  // R15
    isFast   = (mode == tmr8_pkg::MODE_FAST_FF) || (mode == tmr8_pkg::MODE_FAST_A);
    isPc     = (mode == tmr8_pkg::MODE_PC_FF) || (mode == tmr8_pkg::MODE_PC_A);
    isPwm    = isFast | isPc;
    topFromA = (mode == tmr8_pkg::MODE_CLR_CMP) || (mode == tmr8_pkg::MODE_PC_A)
             || (mode == tmr8_pkg::MODE_FAST_A);
    topVal   = topFromA ? cmpA_q : tmr8_pkg::CNT_MAX;                  // R15
    atTop    = (count_q == topVal);
    atBottom = (count_q == tmr8_pkg::CNT_BOTTOM);                      // R17
    // matches are suppressed for one tick after a counter write
    matchA   = tick && !block_q && (count_q == cmpA_q);
    matchB   = tick && !block_q && (count_q == cmpB_q);
  end

  // ----------------------------------------------------------------
  // bus write decode
  // ----------------------------------------------------------------
  // a write commits in the answer cycle, at the edge where the master sees
  // waitrequest low, so pins and registers move together with the handshake
  always_comb begin
    wbyte   = avsWriteData[7:0];
    wrAns   = (busSt_q == TMR8_ANS) && avsWrite && avsByteEnable[0];
    countWr = wrAns && (avsAddress == tmr8_pkg::ADDR_COUNT);
  end

  // ----------------------------------------------------------------
  // counter, flags, compare buffers and waveforms: next state
  // ----------------------------------------------------------------
  always_comb begin
    count_d = count_q;
    down_d  = down_q;
    cmpA_d  = cmpA_q;
    cmpB_d  = cmpB_q;
    // flags_d carries only the hardware set events of this cycle
    flags_d = 3'h0;
    waveA_d = waveA_q;
    waveB_d = waveB_q;
    wrap    = 1'b0;
    block_d = block_q & ~tick;
    // counting, only on tick pulses
    if (tick) begin                                                     // R1 R20
      if (isPc) begin
        if (!down_q && atTop) begin
          down_d  = 1'b1;
          count_d = count_q - 8'h01;
        end else if (down_q && atBottom) begin
          down_d  = 1'b0;
          count_d = count_q + 8'h01;
        end else begin
          count_d = down_q ? count_q - 8'h01 : count_q + 8'h01;
        end
      end else if (atTop) begin
        count_d = tmr8_pkg::CNT_BOTTOM;                                 // R3 R19
        wrap    = 1'b1;
      end else begin
        count_d = count_q + 8'h01;
      end
    end
    // compare value update point
    if ((!isPwm) || (isPc && tick && atTop) || (isFast && tick && wrap)) begin  // R16
      cmpA_d = bufA_q;
      cmpB_d = bufB_q;
    end
    // overflow flag: MAX in 0,2,3; BOTTOM in phase modes; TOP in 7
    if (tick) begin
      if (isPc ? atBottom : (mode == tmr8_pkg::MODE_FAST_A ? atTop
          : count_q == tmr8_pkg::CNT_MAX))                              // R16 R19
        flags_d[tmr8_pkg::FLAG_OVF] = 1'b1;
    end
    if (matchB)
      flags_d[tmr8_pkg::FLAG_MATCH_B] = 1'b1;                           // R2
    if (matchA)
      flags_d[tmr8_pkg::FLAG_MATCH_A] = 1'b1;                           // R2 R3
    // channel A waveform
    case (ctrlA_q[7:6])
      2'b01: begin
        if (matchA && (!isPwm || mode[2]))                              // R6 R8
          waveA_d = ~waveA_q;
      end
      2'b10, 2'b11: begin
        if (!isPwm) begin
          if (matchA) waveA_d = ctrlA_q[6];                             // R6
        end else if (isFast) begin
          if (tick && wrap) waveA_d = ~ctrlA_q[6];                      // R7
          else if (matchA && cmpA_q != topVal) waveA_d = ctrlA_q[6];    // R7 R12
        end else begin
          if (cmpA_q == topVal) begin
            if (tick && atTop) waveA_d = ctrlA_q[6];                    // R13
          end else if (matchA) begin
            waveA_d = down_q ? ~ctrlA_q[6] : ctrlA_q[6];                // R10
          end
        end
      end
      default: waveA_d = waveA_q;
    endcase
    // channel B waveform; action 01 does nothing in PWM modes
    case (ctrlA_q[5:4])
      2'b01: begin
        if (matchB && !isPwm) waveB_d = ~waveB_q;                       // R6 R9
      end
      2'b10, 2'b11: begin
        if (!isPwm) begin
          if (matchB) waveB_d = ctrlA_q[4];                             // R6
        end else if (isFast) begin
          if (tick && wrap) waveB_d = ~ctrlA_q[4];                      // R9
          else if (matchB && cmpB_q != topVal) waveB_d = ctrlA_q[4];    // R9 R12
          else if (tick && atTop && cmpB_q == topVal) waveB_d = ctrlA_q[4];
        end else begin
          if (cmpB_q == topVal) begin
            if (tick && atTop) waveB_d = ctrlA_q[4];                    // R13
          end else if (matchB) begin
            waveB_d = down_q ? ~ctrlA_q[4] : ctrlA_q[4];                // R11
          end
        end
      end
      default: waveB_d = waveB_q;
    endcase
    // software counter write wins over counting and blocks next match
    if (countWr) begin
      count_d = wbyte;
      block_d = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // register file: next state; one wait state, answer in next cycle
  // ----------------------------------------------------------------
  always_comb begin
    busSt_d = TMR8_IDLE;
    ctrlA_d = ctrlA_q;
    ctrlB_d = ctrlB_q;
    bufA_d  = bufA_q;
    bufB_d  = bufB_q;
    rdata_d = rdata_q;
    if (busSt_q == TMR8_IDLE && (avsRead || avsWrite)) begin
      busSt_d = TMR8_ANS;
      rdata_d = 32'h0000_0000;
      if (avsRead) begin
        case (avsAddress)
          tmr8_pkg::ADDR_CTRL_A: rdata_d[7:0] = ctrlA_q & tmr8_pkg::CTRLA_WMASK;  // R14
          tmr8_pkg::ADDR_CTRL_B: rdata_d[7:0] = ctrlB_q & tmr8_pkg::CTRLB_WMASK;
          tmr8_pkg::ADDR_COUNT:  rdata_d[7:0] = count_q;
          tmr8_pkg::ADDR_CMP_A:  rdata_d[7:0] = bufA_q;
          tmr8_pkg::ADDR_CMP_B:  rdata_d[7:0] = bufB_q;
          tmr8_pkg::ADDR_FLAGS:  rdata_d[7:0] = {5'h00, flags_q};
          default:               rdata_d = 32'h0000_0000;   // unmapped reads zero
        endcase
      end
    end
    // writes land in the answer cycle; read data was captured in the idle
    // cycle and stands unchanged until the master takes it
    if (wrAns) begin
      case (avsAddress)
        tmr8_pkg::ADDR_CTRL_A: ctrlA_d = wbyte & tmr8_pkg::CTRLA_WMASK;          // R4 R14
        tmr8_pkg::ADDR_CTRL_B: ctrlB_d = wbyte & tmr8_pkg::CTRLB_WMASK;
        tmr8_pkg::ADDR_CMP_A:  bufA_d  = wbyte;
        tmr8_pkg::ADDR_CMP_B:  bufB_d  = wbyte;
        default:               ctrlA_d = ctrlA_q;         // unmapped writes ignored
      endcase
    end
  end

  // flag clear by writing one; a same-cycle hardware set wins, even on a
  // flag that is already up, so no event is lost to a late clear
  logic [2:0] flagsFinal;
  always_comb begin
    flagsFinal = flags_q;
    if (wrAns && avsAddress == tmr8_pkg::ADDR_FLAGS)
      flagsFinal = flags_q & ~wbyte[2:0];
    flagsFinal = flagsFinal | flags_d;
  end

  // ----------------------------------------------------------------
  // registers only
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      busSt_q <= TMR8_IDLE;
      ctrlA_q <= tmr8_pkg::RST_REG;
      ctrlB_q <= tmr8_pkg::RST_REG;
      count_q <= tmr8_pkg::RST_REG;
      cmpA_q  <= tmr8_pkg::RST_REG;
      cmpB_q  <= tmr8_pkg::RST_REG;
      bufA_q  <= tmr8_pkg::RST_REG;
      bufB_q  <= tmr8_pkg::RST_REG;
      flags_q <= 3'h0;
      down_q  <= 1'b0;
      waveA_q <= 1'b0;
      waveB_q <= 1'b0;
      block_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      busSt_q <= busSt_d;
      ctrlA_q <= ctrlA_d;
      ctrlB_q <= ctrlB_d;
      count_q <= count_d;
      cmpA_q  <= cmpA_d;
      cmpB_q  <= cmpB_d;
      bufA_q  <= bufA_d;
      bufB_q  <= bufB_d;
      flags_q <= flagsFinal;
      down_q  <= down_d;
      waveA_q <= waveA_d;
      waveB_q <= waveB_d;
      block_q <= block_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs; pin driver still needs the port direction bit outside
  // ----------------------------------------------------------------
  always_comb begin
    avsReadData      = rdata_q;
    avsWaitRequest   = (avsRead || avsWrite) && (busSt_q == TMR8_IDLE);
    chanAWaveOut     = waveA_q;
    chanBWaveOut     = waveB_q;
    chanAPinOverride = |ctrlA_q[7:6] && !(isPwm && ctrlA_q[7:6] == 2'b01 && !mode[2]);  // R4 R5 R8
    chanBPinOverride = |ctrlA_q[5:4];                                                  // R4
  end
endmodule
`default_nettype wire

/* tmr8_wave_timer_asserts.sv */
// bound checker for the waveform timer bus handshake and pin ownership
`timescale 1ns/1ps
`default_nettype none
module tmr8_wave_timer_asserts (
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // avalon-mm slave
  input wire logic [7:0]  avsAddress,
  input wire logic        avsRead,
  input wire logic        avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0]  avsByteEnable,
  input wire logic [31:0] avsReadData,
  input wire logic        avsWaitRequest,
  // pins
  input wire logic        extTickPin,
  input wire logic        chanAWaveOut,
  input wire logic        chanBWaveOut,
  input wire logic        chanAPinOverride,
  input wire logic        chanBPinOverride
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // shadow control registers, moved by the same accepted writes
  // ----------------------------------------------------------------
  logic [7:0] ctlA_q, ctlA_d, ctlB_q, ctlB_d;
  logic       wrDone, rdDone, mapped, stopped;
  // next shadow values; lane 0 off means the write is ignored
  always_comb begin
    wrDone = avsWrite && !avsWaitRequest && avsByteEnable[0];
    rdDone = avsRead && !avsWaitRequest;
    mapped = (avsAddress >= tmr8_pkg::ADDR_CTRL_A && avsAddress <= tmr8_pkg::ADDR_CMP_B) ||
             avsAddress == tmr8_pkg::ADDR_FLAGS;
    stopped = ctlB_q[2:0] == tmr8_pkg::SRC_STOP;
    ctlA_d = ctlA_q;
    ctlB_d = ctlB_q;
    if (wrDone && avsAddress == tmr8_pkg::ADDR_CTRL_A) ctlA_d = avsWriteData[7:0];
    if (wrDone && avsAddress == tmr8_pkg::ADDR_CTRL_B) ctlB_d = avsWriteData[7:0];
  end
  // register the shadows
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctlA_q <= 8'h00;
      ctlB_q <= 8'h00;
    end else begin
      ctlA_q <= ctlA_d;
      ctlB_q <= ctlB_d;
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_wait_one_cycle: assert property ((avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest)
    else $error("waitrequest not released after one cycle");
  a_wait_idle_low: assert property (!avsRead && !avsWrite |-> !avsWaitRequest)
    else $error("waitrequest high with no request");
  a_read_upper_zero: assert property (rdDone |-> avsReadData[31:8] == 24'h000000)
    else $error("read data upper bytes not zero");
  a_ctla_resv_zero: assert property (rdDone && avsAddress == tmr8_pkg::ADDR_CTRL_A |->
    avsReadData[7:0] == (ctlA_q & tmr8_pkg::CTRLA_WMASK))
    else $error("control a read value wrong");
  a_unmapped_read_zero: assert property (rdDone && !mapped |-> avsReadData == 32'h00000000)
    else $error("unmapped read not zero");
  // pwm modes are the odd mode codes; action 01 there needs the mode top bit
  a_override_a_pin: assert property (chanAPinOverride == ((ctlA_q[7:6] != 2'b00) &&
    !(ctlA_q[7:6] == 2'b01 && ctlA_q[0] && !ctlB_q[tmr8_pkg::CTRLB_MODE_TOP])))
    else $error("channel a pin ownership wrong");
  a_override_b_pin: assert property (chanBPinOverride == (ctlA_q[5:4] != 2'b00))
    else $error("channel b pin ownership wrong");
  a_wave_held_stopped: assert property ((stopped && !avsWrite) [*2] |=>
    $stable(chanAWaveOut) && $stable(chanBWaveOut))
    else $error("waveform moved with no tick");
  a_read_data_stands: assert property (!avsRead && !avsWrite && $past(!avsRead && !avsWrite) |->
    $stable(avsReadData))
    else $error("read data moved while idle");
  // main scenarios reached
  c_flags_read: cover property (rdDone && avsAddress == tmr8_pkg::ADDR_FLAGS);
  c_wave_a_rise: cover property ($rose(chanAWaveOut));
  c_own_b_rise: cover property ($rose(chanBPinOverride));
endmodule
bind tmr8_wave_timer tmr8_wave_timer_asserts chk_u (.mclk(mclk), .rst(rst), .avsAddress(avsAddress),
  .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
  .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .extTickPin(extTickPin),
  .chanAWaveOut(chanAWaveOut), .chanBWaveOut(chanBWaveOut), .chanAPinOverride(chanAPinOverride),
  .chanBPinOverride(chanBPinOverride));
`default_nettype wire

/* tmr8_wave_timer_tb_top.sv */
// self-checking bench for the 8-bit waveform timer
`timescale 1ns/1ps
`default_nettype none
module tmr8_wave_timer_tb_top;
  // ----------------------------------------------------------------
  // stimulus, observation and scoreboard state
  // ----------------------------------------------------------------
  logic        mclk, rst, avsRead, avsWrite, extTickPin, avsWaitRequest;
  logic        chanAWaveOut, chanBWaveOut, chanAPinOverride, chanBPinOverride;
  logic [7:0]  avsAddress, rdVal;
  logic [31:0] avsWriteData, avsReadData, rnd;
  logic [3:0]  avsByteEnable;
  logic [15:0] expQ[$];
  logic [15:0] note;
  logic [1:0]  acts[4] = '{2'b01, 2'b10, 2'b11, 2'b01};
  logic [3:0]  lvl = 4'b0101;
  int          errTotal, samplesChecked, hiA, hiB;
  // free-running 200 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  tmr8_wave_timer dut_u (.mclk(mclk), .rst(rst), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
    .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .extTickPin(extTickPin),
    .chanAWaveOut(chanAWaveOut), .chanBWaveOut(chanBWaveOut), .chanAPinOverride(chanAPinOverride),
    .chanBPinOverride(chanBPinOverride));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h00000000);
  endfunction
  task automatic chk(input bit ok, input string msg);
    samplesChecked++;
    if (!ok) begin
      errTotal++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // one bus cycle; request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] be);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    @(posedge mclk);
    avsAddress <= a;
    avsWrite <= w;
    avsRead <= !w;
    avsWriteData <= {24'h000000, d};
    avsByteEnable <= be;
    while (!done) begin
      @(posedge mclk);
      done = !avsWaitRequest;
      n++;
      if (n > 20) begin
        chk(1'b0, "bus handshake timed out");
        summarize();
      end
    end
    rdVal = avsReadData[7:0];
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask
  // expected value and compare mask are queued before the read goes out
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    expQ.push_back({m, e});
    bus(1'b0, a, 8'h00, 4'hf);
  endtask
  // run the counter from a preset for a while, then stop it
  task automatic run(input logic [7:0] cnt, input logic [7:0] ctlB, input int cyc);
    wr(tmr8_pkg::ADDR_COUNT, cnt);
    wr(tmr8_pkg::ADDR_CTRL_B, ctlB);
    repeat (cyc) @(posedge mclk);
    wr(tmr8_pkg::ADDR_CTRL_B, 8'h00);
  endtask
  // high-time of both outputs after letting buffered compares settle
  task automatic duty(input int n);
    hiA = 0;
    hiB = 0;
    repeat (600) @(posedge mclk);
    repeat (n) begin
      @(negedge mclk);
      hiA += int'(chanAWaveOut === 1'b1);
      hiB += int'(chanBWaveOut === 1'b1);
    end
  endtask
  task automatic pins(input logic ea, input logic eb);
    @(negedge mclk);
    chk(chanAPinOverride === ea && chanBPinOverride === eb, "pin ownership");
  endtask
  // read monitor: oldest note against each answered read
  always @(negedge mclk) begin
    if (!rst && avsRead && !avsWaitRequest && expQ.size() > 0) begin
      note = expQ.pop_front();
      chk(((avsReadData[7:0] ^ note[7:0]) & note[15:8]) === 8'h00, "read data");
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst, avsRead, avsWrite, extTickPin} = 4'b1000;
    {avsAddress, avsWriteData, avsByteEnable} = '0;
    rnd = 32'h000028b8;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    for (int a = 8'h24; a <= 8'h2c; a++) rd(8'(a), 8'h00, 8'hff);
    wr(tmr8_pkg::ADDR_CTRL_A, 8'hff);
    rd(tmr8_pkg::ADDR_CTRL_A, 8'hf3, 8'hff);
    pins(1'b1, 1'b1);
    wr(tmr8_pkg::ADDR_CTRL_A, 8'h40);
    pins(1'b1, 1'b0);
    wr(tmr8_pkg::ADDR_CTRL_A, 8'h10);
    pins(1'b0, 1'b1);
    wr(8'h30, 8'h5a);
    bus(1'b1, tmr8_pkg::ADDR_CMP_A, 8'h77, 4'h0);
    rd(tmr8_pkg::ADDR_CMP_A, 8'h00, 8'hff);
    repeat (4) begin
      rnd = lfsr(rnd);
      wr(tmr8_pkg::ADDR_CMP_B, rnd[7:0]);
      rd(tmr8_pkg::ADDR_CMP_B, rnd[7:0], 8'hff);
    end
    // match actions in normal mode: toggle, clear, set, toggle
    wr(tmr8_pkg::ADDR_CMP_A, 8'h40);
    wr(tmr8_pkg::ADDR_CMP_B, 8'h40);
    for (int i = 0; i < 4; i++) begin
      wr(tmr8_pkg::ADDR_CTRL_A, {acts[i], acts[i], 4'h0});
      run(8'h3c, 8'h01, 8);
      chk(chanAWaveOut === lvl[i] && chanBWaveOut === lvl[i], "match action");
    end
    rd(tmr8_pkg::ADDR_FLAGS, 8'h06, 8'hff);
    wr(tmr8_pkg::ADDR_FLAGS, 8'h07);
    rd(tmr8_pkg::ADDR_FLAGS, 8'h00, 8'hff);
    wr(tmr8_pkg::ADDR_CTRL_A, 8'h00);
    run(8'hf8, 8'h01, 16);
    rd(tmr8_pkg::ADDR_FLAGS, 8'h01, 8'hff);
    wr(tmr8_pkg::ADDR_FLAGS, 8'h07);
    // clear-on-compare wraps at compare a
    wr(tmr8_pkg::ADDR_CTRL_A, 8'h02);
    wr(tmr8_pkg::ADDR_CMP_A, 8'h10);
    wr(tmr8_pkg::ADDR_CMP_B, 8'h80);
    run(8'h0c, 8'h01, 12);
    rd(tmr8_pkg::ADDR_FLAGS, 8'h02, 8'hff);
    rd(tmr8_pkg::ADDR_COUNT, 8'h00, 8'h00);
    chk(rdVal < 8'h10, "counter passed top");
    // divided and external tick sources
    wr(tmr8_pkg::ADDR_CTRL_A, 8'h00);
    run(8'h00, 8'h02, 797);
    rd(tmr8_pkg::ADDR_COUNT, 8'h00, 8'h00);
    chk(rdVal >= 8'd99 && rdVal <= 8'd101, "divide by 8 count");
    run(8'h00, 8'h07, 0);
    wr(tmr8_pkg::ADDR_CTRL_B, 8'h07);
    repeat (10) begin
      repeat (8) @(posedge mclk);
      extTickPin <= ~extTickPin;
    end
    repeat (8) @(posedge mclk);
    wr(tmr8_pkg::ADDR_CTRL_B, 8'h00);
    rd(tmr8_pkg::ADDR_COUNT, 8'h05, 8'hff);
    // fast and phase-correct pwm: a non-inverting, b inverting
    wr(tmr8_pkg::ADDR_CMP_A, 8'h80);
    wr(tmr8_pkg::ADDR_CMP_B, 8'h40);
    wr(tmr8_pkg::ADDR_CTRL_A, 8'hb3);
    wr(tmr8_pkg::ADDR_CTRL_B, 8'h01);
    duty(1024);
    chk(hiA >= 506 && hiA <= 522 && hiB >= 758 && hiB <= 774, "fast pwm duty");
    wr(tmr8_pkg::ADDR_CTRL_A, 8'hb1);
    duty(1020);
    chk(hiA >= 504 && hiA <= 520 && hiB >= 756 && hiB <= 772, "phase pwm duty");
    // toggle on match only with the mode top bit set
    wr(tmr8_pkg::ADDR_CMP_A, 8'h1f);
    wr(tmr8_pkg::ADDR_CTRL_A, 8'h43);
    wr(tmr8_pkg::ADDR_CTRL_B, 8'h09);
    duty(1024);
    chk(hiA >= 504 && hiA <= 520, "toggle square wave");
    wr(tmr8_pkg::ADDR_CTRL_B, 8'h01);
    duty(1024);
    chk(hiA == 0 || hiA == 1024, "toggle should be off");
    summarize();
  end
endmodule
`default_nettype wire
